// File: rtl/asc_regs.svh
// register offsets, field positions, reset values and timing counts of the scan control block
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define ASC_IDX_DELAY 8'h0C
`define ASC_IDX_DEVICE_CONFIG_REGISTER 8'h10
`define ASC_IDX_SCAN_CONTROL_STATUS 8'h13
`define ASC_IDX_CMD 8'h14
`define ASC_IDX_IRQ_STAT 8'h15
`define ASC_IDX_IRQ_MASK 8'h16

// ==========================================================
// scan_control_status fields
`define ASC_BIT_COMPLETE 15
`define ASC_BIT_TIMEOUT 14
`define ASC_BIT_XFER 13
`define ASC_BIT_DSEL 12
`define ASC_BIT_AUTOOFF 11
`define ASC_DIAG_HI 10
`define ASC_DIAG_LO 8

// ==========================================================
// device_config_register and command fields
`define ASC_BIT_WDOG_DIS 0
`define ASC_OVS_HI 3
`define ASC_OVS_LO 1
`define ASC_BIT_START 0

// ==========================================================
// interrupt status bit positions
`define ASC_IRQ_COMPLETE 0
`define ASC_IRQ_TIMEOUT 1
`define ASC_IRQ_XFER 2

// ==========================================================
// reset values and timing
`define ASC_DELAY_RST 16'h0808
`define ASC_DEVICE_CONFIG_REGISTER_RST 4'h0
`define ASC_WDOG_BASE_NS 2000
`define ASC_CLK_NS 10
`define ASC_WDOG_BASE_CYC (`ASC_WDOG_BASE_NS / `ASC_CLK_NS)

`endif

// File: rtl/asc_pkg.sv
// types shared by the scan control block
package asc_pkg;

	typedef enum logic [1:0] {
		ASC_IDLE = 2'b00,
		ASC_SETTLE = 2'b01,
		ASC_MEASURE = 2'b10,
		ASC_XFER = 2'b11
	} asc_state_t;

	typedef enum logic [2:0] {
		ASC_DIAG_NONE = 3'b000,
		ASC_DIAG_SW_SHORT = 3'b001,
		ASC_DIAG_SW_OPEN = 3'b010,
		ASC_DIAG_ODD_OPEN = 3'b101,
		ASC_DIAG_EVEN_OPEN = 3'b110
	} asc_diag_t;

endpackage : asc_pkg

// File: rtl/asc_ahb_slave.sv
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
`default_nettype none
module asc_ahb_slave
	import asc_pkg::*;
(
	input wire logic hclk, // bus clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // always okay
	output logic [7:0] reg_idx, // register index of pending transfer
	output logic wr_en, // one-cycle write strobe
	output logic [31:0] wr_data, // write data with strobe
	input wire logic [31:0] rd_data // read value of reg_idx
);

	logic pend_reg;
	logic pend_wr_reg;

	// ==========================================================
	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reg <= 1'b0;
			pend_wr_reg <= 1'b0;
			reg_idx <= 8'h00;
		end else if (hsel && hready && htrans[1] && hreadyout) begin
			pend_reg <= 1'b1;
			pend_wr_reg <= hwrite;
			reg_idx <= haddr[9:2];
		end else begin
			pend_reg <= 1'b0;
		end
	end

	// ==========================================================
	// data phase: one wait state, then answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
		end else if (pend_reg) begin
			hreadyout <= 1'b1;
			hrdata <= pend_wr_reg ? 32'h0000_0000 : rd_data;
		end else if (hsel && hready && htrans[1]) begin
			hreadyout <= 1'b0;
		end
	end

	assign hresp = 1'b0;
	assign wr_en = pend_reg && pend_wr_reg;
	assign wr_data = hwdata;

endmodule : asc_ahb_slave
`default_nettype wire

// File: rtl/asc_timer.sv
// loadable down counter giving a one-cycle pulse on expiry
`timescale 1ns/1ps
`default_nettype none
module asc_timer
	import asc_pkg::*;
#(
	parameter int W = 24
) (
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, active low
	input wire logic load, // start counting from load_val
	input wire logic [W-1:0] load_val, // cycles until expiry
	input wire logic stop, // abandon count
	output logic expire // one-cycle pulse
);

	logic [W-1:0] cnt_reg;
	logic run_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (load) begin
				cnt_reg <= load_val;
				run_reg <= 1'b1;
			end else if (stop) begin
				run_reg <= 1'b0;
			end else if (run_reg) begin
				if (cnt_reg <= W'(1)) begin
					run_reg <= 1'b0;
					expire <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - W'(1);
				end
			end
		end
	end

endmodule : asc_timer
`default_nettype wire

// File: rtl/asc_scan_ctrl.sv
// scan control and status block of a cell-voltage acquisition sequencer
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"
module asc_scan_ctrl
	import asc_pkg::*;
#(
	parameter int WDOG_W = 24,
	parameter int WDOG_BASE = `ASC_WDOG_BASE_CYC
) (
	input wire logic hclk, // bus and core clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // response, always okay
	input wire logic meas_done, // pulse: measurement finished
	input wire logic xfer_done, // pulse: results now in data registers
	output logic meas_start_reg, // pulse: begin measuring
	output logic xfer_req_reg, // pulse: move all results at once
	output logic balance_open_reg, // force balancing switches open
	output logic diag_override_reg, // diagnostic overrides enables and mux
	output logic [3:0] diag_test_reg, // short, open, odd, even one-hot
	output logic alert_update_reg, // pulse: refresh balance switch alerts
	output logic irq_reg // level interrupt
);

	logic [7:0] reg_idx;
	logic wr_en;
	logic [31:0] wr_data;
	logic [31:0] rd_data;
	logic [31:0] hrdata_w;
	logic hreadyout_w;
	logic hresp_w;

	asc_state_t state_reg, state_next;
	logic complete_reg, timeout_reg, xfer_flag_reg;
	logic dsel_reg, auto_off_reg;
	logic [2:0] diag_reg;
	logic [15:0] delay_reg;
	logic [3:0] device_config_register_reg;
	logic [2:0] irq_stat_reg, irq_mask_reg;
	logic start_req;
	logic wr_ctrl;
	logic settle_load, settle_exp;
	logic wdog_load, wdog_exp, wdog_stop;
	logic [7:0] settle_val;
	logic [WDOG_W-1:0] wdog_val;
	logic set_complete, set_timeout, set_xfer;
	logic busy;

	// ==========================================================
	// bus front end
	asc_ahb_slave u_bus (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout_w),
		.hrdata(hrdata_w),
		.hresp(hresp_w),
		.reg_idx(reg_idx),
		.wr_en(wr_en),
		.wr_data(wr_data),
		.rd_data(rd_data)
	);

	assign hreadyout = hreadyout_w;
	assign hrdata = hrdata_w;
	assign hresp = hresp_w;

	// ==========================================================
	// register read mux; unmapped indices read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		case (reg_idx)
			`ASC_IDX_DELAY: rd_data[15:0] = delay_reg;
			`ASC_IDX_DEVICE_CONFIG_REGISTER: rd_data[3:0] = device_config_register_reg;
			`ASC_IDX_SCAN_CONTROL_STATUS: rd_data[15:8] = {complete_reg, timeout_reg, xfer_flag_reg,
				dsel_reg, auto_off_reg, diag_reg};
			`ASC_IDX_CMD: rd_data[0] = busy;
			`ASC_IDX_IRQ_STAT: rd_data[2:0] = irq_stat_reg;
			`ASC_IDX_IRQ_MASK: rd_data[2:0] = irq_mask_reg;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	assign wr_ctrl = wr_en && (reg_idx == `ASC_IDX_SCAN_CONTROL_STATUS);
	assign start_req = wr_en && (reg_idx == `ASC_IDX_CMD) && wr_data[`ASC_BIT_START];
	assign busy = (state_reg != ASC_IDLE);

	// ==========================================================
	// configuration registers written by software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			delay_reg <= `ASC_DELAY_RST;
			device_config_register_reg <= `ASC_DEVICE_CONFIG_REGISTER_RST;
			irq_mask_reg <= 3'h0;
		end else if (wr_en) begin
			if (reg_idx == `ASC_IDX_DELAY) begin
				delay_reg <= wr_data[15:0];
			end
			if (reg_idx == `ASC_IDX_DEVICE_CONFIG_REGISTER) begin
				device_config_register_reg <= wr_data[3:0];
			end
			if (reg_idx == `ASC_IDX_IRQ_MASK) begin
				irq_mask_reg <= wr_data[2:0];
			end
		end
	end

	// mode bits are only taken while idle, so a scan never sees them change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dsel_reg <= 1'b0;
			auto_off_reg <= 1'b0;
			diag_reg <= 3'h0;
		end else if (wr_ctrl && !busy) begin
			dsel_reg <= wr_data[`ASC_BIT_DSEL];
			auto_off_reg <= wr_data[`ASC_BIT_AUTOOFF];
			diag_reg <= wr_data[`ASC_DIAG_HI:`ASC_DIAG_LO];
		end
	end

	// ==========================================================
	// sticky status flags: write zero clears, write one keeps, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			complete_reg <= 1'b0;
			timeout_reg <= 1'b0;
			xfer_flag_reg <= 1'b0;
		end else begin
			complete_reg <= set_complete || (complete_reg &&
				!(wr_ctrl && !wr_data[`ASC_BIT_COMPLETE]));
			timeout_reg <= set_timeout || (timeout_reg &&
				!(wr_ctrl && !wr_data[`ASC_BIT_TIMEOUT]));
			xfer_flag_reg <= set_xfer || (xfer_flag_reg &&
				!(wr_ctrl && !wr_data[`ASC_BIT_XFER]));
		end
	end

	// ==========================================================
	// sequencer
	always_comb begin
		state_next = state_reg;
		settle_load = 1'b0;
		wdog_load = 1'b0;
		set_complete = 1'b0;
		set_timeout = 1'b0;
		set_xfer = 1'b0;
		case (state_reg)
			ASC_IDLE: begin
				if (start_req && !complete_reg) begin
					wdog_load = !device_config_register_reg[`ASC_BIT_WDOG_DIS];
					settle_load = auto_off_reg;
					state_next = auto_off_reg ? ASC_SETTLE : ASC_MEASURE;
				end
			end
			ASC_SETTLE: begin
				if (settle_exp) begin
					state_next = ASC_MEASURE;
				end
			end
			ASC_MEASURE: begin
				if (meas_done) begin
					state_next = ASC_XFER;
				end
			end
			ASC_XFER: begin
				if (xfer_done) begin
					set_xfer = 1'b1;
					set_complete = 1'b1;
					state_next = ASC_IDLE;
				end
			end
			default: state_next = ASC_IDLE;
		endcase
		// overrun abandons the scan unreported as complete, unless completion is set in the same cycle
		if (busy && wdog_exp && !device_config_register_reg[`ASC_BIT_WDOG_DIS] && !set_complete) begin
			set_timeout = 1'b1;
			state_next = ASC_IDLE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ASC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// settle delay and watchdog timers
	assign settle_val = dsel_reg ? delay_reg[15:8] : delay_reg[7:0];
	// limit doubles with each oversampling step
	assign wdog_val = WDOG_W'(WDOG_BASE) << device_config_register_reg[`ASC_OVS_HI:`ASC_OVS_LO];
	assign wdog_stop = busy && (state_next == ASC_IDLE);

	asc_timer #(.W(8)) u_settle (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(settle_load),
		.load_val(settle_val),
		.stop(wdog_stop),
		.expire(settle_exp)
	);

	asc_timer #(.W(WDOG_W)) u_wdog (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(wdog_load),
		.load_val(wdog_val),
		.stop(wdog_stop),
		.expire(wdog_exp)
	);

	// ==========================================================
	// datapath and switch control outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meas_start_reg <= 1'b0;
			xfer_req_reg <= 1'b0;
			alert_update_reg <= 1'b0;
		end else begin
			meas_start_reg <= (state_reg != ASC_MEASURE) && (state_next == ASC_MEASURE);
			xfer_req_reg <= (state_reg == ASC_MEASURE) && (state_next == ASC_XFER);
			alert_update_reg <= set_xfer && (diag_test_reg != 4'h0);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			balance_open_reg <= 1'b0;
			diag_override_reg <= 1'b0;
			diag_test_reg <= 4'h0;
		end else begin
			balance_open_reg <= auto_off_reg && (state_next != ASC_IDLE);
			case (diag_reg)
				ASC_DIAG_SW_SHORT: diag_test_reg <= 4'b1000;
				ASC_DIAG_SW_OPEN: diag_test_reg <= 4'b0100;
				ASC_DIAG_ODD_OPEN: diag_test_reg <= 4'b0010;
				ASC_DIAG_EVEN_OPEN: diag_test_reg <= 4'b0001;
				default: diag_test_reg <= 4'b0000;
			endcase
			diag_override_reg <= (diag_reg != 3'h0) && (state_next != ASC_IDLE);
		end
	end

	// ==========================================================
	// interrupt status: write one clears, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_reg <= 3'h0;
			irq_reg <= 1'b0;
		end else begin
			irq_stat_reg <= {set_xfer, set_timeout, set_complete} | (irq_stat_reg &
				~((wr_en && reg_idx == `ASC_IDX_IRQ_STAT) ? wr_data[2:0] : 3'h0));
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// ==========================================================
	// checks
	sequence start_taken_s;
		state_reg == ASC_IDLE && start_req && !complete_reg;
	endsequence

	sequence settle_path_s;
		start_taken_s ##0 auto_off_reg;
	endsequence

	blocked_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == ASC_IDLE && complete_reg) |=> state_reg == ASC_IDLE)
		else $error("scan started while completion flag set");

	complete_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == ASC_XFER && xfer_done) |=> complete_reg && xfer_flag_reg)
		else $error("completion or transfer flag not set at end of scan");

	complete_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(complete_reg && !(wr_ctrl && !wr_data[`ASC_BIT_COMPLETE])) |=> complete_reg)
		else $error("completion flag dropped without a zero write");

	timeout_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(timeout_reg && !(wr_ctrl && !wr_data[`ASC_BIT_TIMEOUT])) |=> timeout_reg)
		else $error("timeout flag dropped without a zero write");

	wdog_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		device_config_register_reg[`ASC_BIT_WDOG_DIS] |=> !$rose(timeout_reg))
		else $error("timeout raised while watchdog disabled");

	xfer_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_ctrl && !wr_data[`ASC_BIT_XFER] && !set_xfer) |=> !xfer_flag_reg)
		else $error("transferred flag not cleared by zero write");

	set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(set_timeout && wr_ctrl && !wr_data[`ASC_BIT_TIMEOUT]) |=> timeout_reg)
		else $error("timeout event lost to a clear");

	complete_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(set_complete && wr_ctrl && !wr_data[`ASC_BIT_COMPLETE]) |=> complete_reg)
		else $error("completion event lost to a clear");

	settle_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
		settle_path_s |=> state_reg == ASC_SETTLE ##1 !meas_start_reg)
		else $error("measurement began before settle delay");

	balance_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == ASC_MEASURE && !auto_off_reg) |-> !balance_open_reg)
		else $error("switches opened with auto disable off");

	diag_decode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(diag_reg == 3'b011 || diag_reg == 3'b100 || diag_reg == 3'b111)
		|=> diag_test_reg == 4'b0000)
		else $error("reserved diagnostic code selected a test");

endmodule : asc_scan_ctrl
`default_nettype wire

// File: bench/acquisition_scan_control_bench.sv
// self-checking bench of the scan control block over its AHB-Lite port
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"
module acquisition_scan_control_bench;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rdv, m;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic meas_done, xfer_done, meas_start_reg, xfer_req_reg, balance_open_reg;
	logic diag_override_reg, alert_update_reg, irq_reg;
	logic [3:0] diag_test_reg;
	logic [7:0] cd, dd;
	int n_errors, comparisons, cycles, n_starts, n, k, nn;
	logic [31:0] exp_q[$], got_q[$];
	string nm_q[$];
	localparam logic [31:0] a_dly = {22'h0, `ASC_IDX_DELAY, 2'b00};
	localparam logic [31:0] a_cfg = {22'h0, `ASC_IDX_DEVICE_CONFIG_REGISTER, 2'b00};
	localparam logic [31:0] a_sc = {22'h0, `ASC_IDX_SCAN_CONTROL_STATUS, 2'b00};
	localparam logic [31:0] a_cmd = {22'h0, `ASC_IDX_CMD, 2'b00};
	localparam logic [31:0] a_ist = {22'h0, `ASC_IDX_IRQ_STAT, 2'b00};
	localparam logic [31:0] a_imk = {22'h0, `ASC_IDX_IRQ_MASK, 2'b00};
	localparam logic [31:0] a_bad = 32'h80;
	assign hready = hreadyout;

	// short watchdog base keeps timeout runs brief
	asc_scan_ctrl #(.WDOG_BASE(20)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.meas_done(meas_done), .xfer_done(xfer_done), .meas_start_reg(meas_start_reg),
		.xfer_req_reg(xfer_req_reg), .balance_open_reg(balance_open_reg),
		.diag_override_reg(diag_override_reg), .diag_test_reg(diag_test_reg),
		.alert_update_reg(alert_update_reg), .irq_reg(irq_reg));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// ==========================================================
	// checking
	task automatic end_sim;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic note(input string s, input logic [31:0] e, input logic [31:0] g);
		nm_q.push_back(s);
		exp_q.push_back(e);
		got_q.push_back(g);
	endtask : note

	always @(negedge hclk) begin
		while (exp_q.size() > 0) begin
			comparisons++;
			if (got_q[0] !== exp_q[0]) begin
				n_errors++;
				$display("[ERR] %s expected %h seen %h", nm_q[0], exp_q[0], got_q[0]);
			end
			nm_q.delete(0);
			exp_q.delete(0);
			got_q.delete(0);
		end
	end

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (meas_start_reg === 1'b1)
			n_starts <= n_starts + 1;
		if (cycles == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	// ==========================================================
	// bus and scan helpers
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		int t;
		t = 0;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do begin
			@(posedge hclk);
			t++;
		end while (hready !== 1'b1 && t < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge hclk);
			t++;
		end while (hready !== 1'b1 && t < 50);
		rdv = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
		bus(1'b0, a, 32'h0);
		note(s, e, rdv);
	endtask : rd

	function automatic logic sig(input int w);
		case (w)
			0: return meas_start_reg;
			1: return xfer_req_reg;
			default: return alert_update_reg;
		endcase
	endfunction : sig

	// a pulse launched at the edge that ends the caller's wait is still seen
	task automatic wp(input int w, input int lim);
		n = 0;
		while (sig(w) !== 1'b1 && n <= lim) begin
			@(posedge hclk);
			n++;
		end
	endtask : wp

	task automatic fire(input int w);
		if (w == 0)
			meas_done <= 1'b1;
		else
			xfer_done <= 1'b1;
		@(posedge hclk);
		meas_done <= 1'b0;
		xfer_done <= 1'b0;
	endtask : fire

	function automatic logic [3:0] dexp(input int c);
		case (c)
			1: return 4'h8;
			2: return 4'h4;
			5: return 4'h2;
			6: return 4'h1;
			default: return 4'h0;
		endcase
	endfunction : dexp

	task automatic scan(input int lo, input int hi, input logic dg, input logic bo, input int st);
		wr(a_cmd, 32'h1);
		wp(0, 3000);
		note("start delay in range", 32'h1, 32'(n >= lo && n <= hi));
		note("balance open", 32'(bo), 32'(balance_open_reg));
		note("diag override", 32'(dg), 32'(diag_override_reg));
		repeat (st) @(posedge hclk);
		fire(0);
		wp(1, 8);
		note("transfer request", 32'h1, 32'(n <= 3));
		if (bo) begin
			// zero write to the flags lands in the cycle that sets them
			fork
				wr(a_sc, 32'h0);
				begin
					@(posedge hclk);
					fire(1);
				end
			join
		end else begin
			fire(1);
		end
		if (dg) begin
			wp(2, 8);
			note("alert update", 32'h1, 32'(n <= 3));
		end
		repeat (3) @(posedge hclk);
		note("balance released", 32'h0, 32'(balance_open_reg));
	endtask : scan

	// ==========================================================
	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		meas_done = 1'b0;
		xfer_done = 1'b0;
		n_errors = 0;
		comparisons = 0;
		cycles = 0;
		n_starts = 0;
		void'($urandom(1971));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(a_sc, 32'h0, "scan ctrl reset");
		rd(a_dly, 32'h0808, "delay reset");
		rd(a_cfg, 32'h0, "config reset");
		note("bus response", 32'h0, 32'(hresp));
		wr(a_bad, 32'hFFFF);
		rd(a_bad, 32'h0, "unmapped read");
		for (int c = 0; c < 8; c++) begin
			wr(a_sc, 32'(c) << 8);
			repeat (2) @(posedge hclk);
			note("diag decode", 32'(dexp(c)), 32'(diag_test_reg));
			rd(a_sc, 32'(c) << 8, "diag field");
		end
		wr(a_sc, 32'h0);
		wr(a_imk, 32'h7);
		wr(a_cfg, 32'h1);
		// watchdog off: a stalled scan must still finish cleanly
		scan(0, 0, 1'b0, 1'b0, 100);
		rd(a_sc, 32'hA000, "flags after scan");
		note("irq raised", 32'h1, 32'(irq_reg));
		rd(a_ist, 32'h5, "irq status");
		wr(a_imk, 32'h0);
		repeat (2) @(posedge hclk);
		note("irq masked", 32'h0, 32'(irq_reg));
		wr(a_imk, 32'h7);
		repeat (2) @(posedge hclk);
		note("irq unmasked", 32'h1, 32'(irq_reg));
		wr(a_ist, 32'h5);
		repeat (2) @(posedge hclk);
		note("irq cleared", 32'h0, 32'(irq_reg));
		k = n_starts;
		wr(a_cmd, 32'h1);
		repeat (10) @(posedge hclk);
		note("start blocked", 32'(k), 32'(n_starts));
		wr(a_sc, 32'hE000);
		rd(a_sc, 32'hA000, "write ones kept");
		wr(a_sc, 32'h2000);
		rd(a_sc, 32'h2000, "complete cleared");
		wr(a_sc, 32'h0);
		rd(a_sc, 32'h0, "transferred cleared");
		for (int s = 0; s < 2; s++) begin
			cd = 8'(2 + $urandom % 20);
			dd = 8'(2 + $urandom % 20);
			wr(a_dly, {16'h0, dd, cd});
			rd(a_dly, {16'h0, dd, cd}, "delay value");
			m = (s == 0) ? 32'h0D00 : 32'h1800;
			nn = (s == 0) ? int'(cd) : int'(dd);
			wr(a_sc, m);
			scan(nn, nn + 4, s == 0, 1'b1, 0);
			rd(a_sc, 32'hA000 | m, "flags with mode");
			wr(a_sc, m);
		end
		wr(a_sc, 32'h0);
		// oversampling one doubles the limit to 40 cycles
		wr(a_cfg, 32'h2);
		wr(a_cmd, 32'h1);
		repeat (25) @(posedge hclk);
		rd(a_sc, 32'h0, "no early timeout");
		repeat (30) @(posedge hclk);
		rd(a_sc, 32'h4000, "timeout");
		repeat (60) @(posedge hclk);
		rd(a_sc, 32'h4000, "timeout held");
		rd(a_cmd, 32'h0, "aborted scan idle");
		wr(a_sc, 32'hA000);
		rd(a_sc, 32'h0, "timeout cleared");
		@(negedge hclk);
		@(posedge hclk);
		end_sim();
	end
endmodule : acquisition_scan_control_bench
`default_nettype wire
